// ### hw/iwp_slave.sv
// Function
// - sample every incoming data bit on the rising serial clock edge
// - change transmitted data only after a falling serial clock edge
// - data pin is open drain: pull low or release only
// - two select pins form the low two bits of the address
// - respond only when received select bits match the select pins
// - one 7-bit volatile register holds the wiper position
// - 00h selects lowest tap, 7Fh highest, monotonic between
// - wiper register loads 20h at reset
// - wiper position takes data bits 6:0; bit 7 of the byte is dropped
// - new tap switch closes before the old one opens
// - read of address 0 returns the wiper register
// - write to address 0 changes only the wiper register
// - slave only: never drives clock, never starts a transfer
// - bytes travel most significant bit first both ways
// - id byte: fixed code, two select bits, direction bit
// - write is id, address, data; each byte acknowledged
// - read sends one byte: wiper value, then master nacks
// - start/stop are data edges while clock high; idle until start
`timescale 1ns/1ps
module iwp_slave
  import iwp_pkg::*;
#(
  parameter logic [4:0] DEVICE_CODE = 5'h15, // arbitrary value
  parameter int         TAPS        = TAP_COUNT
) (
  // system clock and reset
  input  wire logic            clock,
  input  wire logic            rstn,
  // serial link clock from the master
  input  wire logic            link_clock,
  // serial data, open drain
  input  wire logic            sda_in,
  output logic                 sda_out,
  output logic                 sda_oe,
  // address select straps
  input  wire logic            bus_address_select_high,
  input  wire logic            bus_address_select_low,
  // wiper
  output logic      [6:0]      wiper_position,
  output logic      [TAPS-1:0] tap_enable
);

  // ******************************************************
  // link-domain reset and data synchronisation
  // ******************************************************
  logic       link_rst_s1;
  logic       link_rstn;
  logic [1:0] sel_sync;
  logic       sda_s;
  logic       sda_prev;

  always_ff @(posedge link_clock) begin
    link_rst_s1 <= rstn;
    link_rstn   <= link_rst_s1;
  end

  // ******************************************************
  // start and stop detection
  // ******************************************************
  // start/stop are seen on system clock: link clock stops while high
  logic scl_s;
  logic scl_prev;
  logic start_seen;
  logic stop_seen;

  iwp_sync #(.WIDTH(4)) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({link_clock, sda_in, bus_address_select_high,
                bus_address_select_low}),
    .sync_out ({scl_s, sda_s, sel_sync})
  );

  always_ff @(posedge clock) begin
    if (!rstn) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  assign start_seen = scl_s && scl_prev && sda_prev && !sda_s;
  assign stop_seen  = scl_s && scl_prev && !sda_prev && sda_s;

  // toggles carry start/stop events into the link domain
  logic start_tgl;
  logic stop_tgl;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      start_tgl <= 1'b0;
      stop_tgl  <= 1'b0;
    end else begin
      if (start_seen)
        start_tgl <= ~start_tgl;
      if (stop_seen)
        stop_tgl <= ~stop_tgl;
    end
  end

  // sda is stable around rising clock edges, so a plain flop is safe;
  // the toggles change while clock is high and settle by the next edge
  logic start_ack;
  logic stop_ack;
  logic start_ev;
  logic stop_ev;
  assign start_ev = start_tgl != start_ack;
  assign stop_ev  = stop_tgl != stop_ack;

  // ******************************************************
  // link-side protocol engine
  // ******************************************************
  iwp_state_t state;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic       is_read;
  logic       addr_ok;
  logic       ack_next_send;
  logic [6:0] wr_data;
  logic       wr_tgl;
  logic [6:0] rd_snap;
  logic       addr_done;

  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic       b);
    return {s[6:0], b};
  endfunction

  // only rising-edge sampling here; the device never drives clock
  always_ff @(posedge link_clock) begin
    if (!link_rstn) begin
      state         <= IWP_IDLE;
      bit_cnt       <= 3'h0;
      shift         <= 8'h00;
      is_read       <= 1'b0;
      addr_ok       <= 1'b0;
      ack_next_send <= 1'b0;
      wr_data       <= WIPER_RESET;
      wr_tgl        <= 1'b0;
      start_ack     <= 1'b0;
      stop_ack      <= 1'b0;
    end else begin
      start_ack <= start_tgl;
      stop_ack  <= stop_tgl;
      if (start_ev) begin
        state   <= IWP_ID;
        bit_cnt <= 3'h1;
        shift   <= {7'h00, sda_in};
      end else if (stop_ev) begin
        state <= IWP_IDLE;
      end else begin
        unique case (state)
          IWP_IDLE: begin
            bit_cnt <= 3'h0;
          end
          IWP_ID, IWP_ADDR, IWP_DATA: begin
            shift   <= shift_in(shift, sda_in);
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              if (state == IWP_ID) begin
                is_read <= sda_in;
                if (shift[6:2] == DEVICE_CODE &&
                    shift[1:0] == sel_sync) begin
                  state         <= IWP_ACK;
                  ack_next_send <= (sda_in == DIR_READ);
                end else begin
                  state <= IWP_IDLE;
                end
              end else if (state == IWP_ADDR) begin
                addr_ok       <= ({shift[6:0], sda_in} ==
                                  WIPER_POSITION_OFFSET);
                state         <= IWP_ACK;
                ack_next_send <= 1'b0;
              end else begin
                if (addr_ok) begin
                  // low seven bits of the byte, last bit still on the pin
                  wr_data <= {shift[5:0], sda_in};
                  wr_tgl  <= ~wr_tgl;
                end
                state         <= IWP_ACK;
                ack_next_send <= 1'b0;
              end
            end
          end
          IWP_ACK: begin
            bit_cnt <= 3'h0;
            shift   <= 8'h00;
            if (ack_next_send)
              state <= IWP_SEND;
            else if (is_read)
              state <= IWP_IDLE;
            else if (addr_done)
              state <= IWP_DATA;
            else
              state <= IWP_ADDR;
          end
          IWP_SEND: begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
              state <= IWP_MACK;
          end
          IWP_MACK: begin
            // one byte only; the master's ack bit ends it whatever its value, stop follows
            state <= IWP_IDLE;
          end
          default: state <= IWP_IDLE;
        endcase
      end
    end
  end

  // track byte index of a write so the data byte follows the address
  always_ff @(posedge link_clock) begin
    if (!link_rstn)
      addr_done <= 1'b0;
    else if (start_ev)
      addr_done <= 1'b0;
    else if (state == IWP_ADDR && bit_cnt == 3'h7)
      addr_done <= 1'b1;
  end

  // ******************************************************
  // open-drain data driver, updated on falling clock
  // ******************************************************
  logic drive_low;
  always_ff @(negedge link_clock) begin
    if (!link_rstn) begin
      drive_low <= 1'b0;
      rd_snap   <= WIPER_RESET;
    end else begin
      unique case (state)
        IWP_ACK:  begin
          drive_low <= 1'b1;
          rd_snap   <= wiper_position;
        end
        IWP_SEND: drive_low <= !(bit_cnt == 3'h0 ? 1'b0
                                 : rd_snap[3'h7 - bit_cnt]);
        default:  drive_low <= 1'b0;
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  // ******************************************************
  // wiper register, system clock domain
  // ******************************************************
  logic wr_s1;
  logic wr_s2;
  logic wr_s3;
  logic [6:0] next_wiper;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_s1 <= 1'b0;
      wr_s2 <= 1'b0;
      wr_s3 <= 1'b0;
    end else begin
      wr_s1 <= wr_tgl;
      wr_s2 <= wr_s1;
      wr_s3 <= wr_s2;
    end
  end

  // data written is 7 bits wide, so it stays within 00h..7Fh
  always_comb begin
    next_wiper = wr_data;
    if (next_wiper > WIPER_MAX)
      next_wiper = WIPER_MAX;
    if (next_wiper < WIPER_MIN)
      next_wiper = WIPER_MIN;
  end

  always_ff @(posedge clock) begin
    if (!rstn)
      wiper_position <= WIPER_RESET;
    else if (wr_s2 != wr_s3)
      wiper_position <= next_wiper;
  end

  iwp_tap_switch #(.TAPS(TAPS)) u_taps (
    .clock      (clock),
    .rstn       (rstn),
    .position   (wiper_position),
    .tap_enable (tap_enable)
  );

endmodule

// ### hw/iwp_pkg.sv
package iwp_pkg;

  // ******************************************************
  // register map and reset values
  // ******************************************************
  localparam logic [7:0] WIPER_POSITION_OFFSET = 8'h00;
  localparam int         WIPER_WIDTH           = 7;
  localparam int         TAP_COUNT             = 128;
  // 20h taken as printed; the mid-scale remark conflicts with it
  localparam logic [6:0] WIPER_RESET           = 7'h20;
  localparam logic [6:0] WIPER_MIN             = 7'h00;
  localparam logic [6:0] WIPER_MAX             = 7'h7f;

  // ******************************************************
  // identification byte layout
  // ******************************************************
  localparam int         ID_CODE_MSB   = 7;
  localparam int         ID_CODE_LSB   = 3;
  localparam int         ID_SEL_HI_BIT = 2;
  localparam int         ID_SEL_LO_BIT = 1;
  localparam int         ID_DIR_BIT    = 0;
  localparam logic       DIR_READ      = 1'b1;
  localparam int         BYTE_LAST_BIT = 7;

  // ******************************************************
  // tap switching
  // ******************************************************
  localparam logic [3:0] MAKE_HOLD_CYCLES = 4'h2;

  // ******************************************************
  // slave protocol states
  // ******************************************************
  typedef enum logic [6:0] {
    IWP_IDLE     = 7'b0000001,
    IWP_ID       = 7'b0000010,
    IWP_ACK      = 7'b0000100,
    IWP_ADDR     = 7'b0001000,
    IWP_DATA     = 7'b0010000,
    IWP_SEND     = 7'b0100000,
    IWP_MACK     = 7'b1000000
  } iwp_state_t;

endpackage

// ### hw/iwp_sync.sv
`timescale 1ns/1ps
module iwp_sync
  import iwp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ### hw/iwp_tap_switch.sv
`timescale 1ns/1ps
module iwp_tap_switch
  import iwp_pkg::*;
#(
  parameter int TAPS = TAP_COUNT
) (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            rstn,
  // wiper position
  input  wire logic [6:0]      position,
  // one enable per tap switch
  output logic      [TAPS-1:0] tap_enable
);

  // ******************************************************
  // make before break
  // ******************************************************
  logic [6:0] current;
  logic [6:0] target;
  logic [3:0] hold;
  logic       moving;

  function automatic logic [TAPS-1:0] one_hot(input logic [6:0] idx);
    logic [TAPS-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  // a move overlaps both switches for a short hold, then drops the old one
  always_ff @(posedge clock) begin
    if (!rstn) begin
      current    <= WIPER_RESET;
      target     <= WIPER_RESET;
      hold       <= 4'h0;
      moving     <= 1'b0;
      tap_enable <= one_hot(WIPER_RESET);
    end else if (!moving && position != current) begin
      target     <= position;
      hold       <= MAKE_HOLD_CYCLES;
      moving     <= 1'b1;
      tap_enable <= one_hot(current) | one_hot(position);
    end else if (moving && hold != 4'h0) begin
      hold <= hold - 4'h1;
    end else if (moving) begin
      current    <= target;
      moving     <= 1'b0;
      tap_enable <= one_hot(target);
    end
  end

endmodule

// ### test/iwp_slave_monitor.sv
`timescale 1ns/1ps
module iwp_slave_monitor
  import iwp_pkg::*;
#(
  parameter int TAPS = TAP_COUNT
) (
  // system side
  input wire logic            clock,
  input wire logic            rstn,
  // bus side
  input wire logic            link_clock,
  input wire logic            sda_in,
  input wire logic            sda_out,
  input wire logic            sda_oe,
  input wire logic            bus_address_select_high,
  input wire logic            bus_address_select_low,
  // wiper
  input wire logic [6:0]      wiper_position,
  input wire logic [TAPS-1:0] tap_enable
);
  default clocking cb @(posedge clock); endclocking

  property p_od;
    disable iff (!rstn) sda_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("sda driven high");

  // data may only move while the link clock is low
  property p_still_high;
    disable iff (!rstn) link_clock && $past(link_clock) |-> $stable(sda_oe);
  endproperty
  a_still_high: assert property (p_still_high) else $error("sda moved");

  property p_pull_len;
    disable iff (!rstn) $rose(sda_oe) |-> sda_oe [*8];
  endproperty
  a_pull_len: assert property (p_pull_len) else $error("pull short");

  property p_wiper_reset;
    !rstn |=> wiper_position == WIPER_RESET;
  endproperty
  a_wiper_reset: assert property (p_wiper_reset) else $error("wiper rst");

  property p_tap_reset;
    !rstn |=> tap_enable == (TAPS'(1) << WIPER_RESET);
  endproperty
  a_tap_reset: assert property (p_tap_reset) else $error("tap rst");

  property p_connected;
    disable iff (!rstn) tap_enable != '0;
  endproperty
  a_connected: assert property (p_connected) else $error("no tap");

  property p_settled;
    disable iff (!rstn) $stable(wiper_position) [*8] |->
      $onehot(tap_enable) && tap_enable[wiper_position];
  endproperty
  a_settled: assert property (p_settled) else $error("tap decode");

  // a lone tap is only reached through an overlap of two
  property p_make_first;
    disable iff (!rstn) $changed(tap_enable) && $onehot(tap_enable) |->
      $countones($past(tap_enable)) == 2;
  endproperty
  a_make_first: assert property (p_make_first) else $error("break 1st");

  c_pull: cover property (disable iff (!rstn) $rose(sda_oe));
  c_move: cover property (disable iff (!rstn) $changed(wiper_position));
  c_overlap: cover property (disable iff (!rstn) $countones(tap_enable) == 2);
endmodule

// ### test/iwp_master.sv
`timescale 1ns/1ps
module iwp_master #(
  parameter int HP = 200
) (
  // bus lines
  output logic      scl,
  output logic      pull_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // short pulses so the link side sees reset
  // four edges: two to carry reset across, two with it applied
  task pulses();
    repeat (4) begin
      #3 scl = 1'b0;
      #3 scl = 1'b1;
    end
  endtask
  task start_c();
    #HP pull_low = 1'b1;
    #HP scl = 1'b0;
  endtask
  task bit_io(input logic b, output logic r);
    #(HP/2) pull_low = !b;
    #(HP/2) scl = 1'b1;
    #(HP/2) r = sda;
    #(HP/2) scl = 1'b0;
  endtask
  task put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task get(output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
    bit_io(1'b1, r);
  endtask
  task stop_c();
    #(HP/2) pull_low = 1'b1;
    #(HP/2) scl = 1'b1;
    #HP pull_low = 1'b0;
    #HP;
  endtask
endmodule

// ### test/iwp_slave_bench.sv
`timescale 1ns/1ps
module iwp_slave_bench;
  import iwp_pkg::*;
  localparam logic [4:0] CODE = 5'h0b; // arbitrary value
  typedef struct packed {
    logic [1:0] pins;
    logic [1:0] sel;
    logic [7:0] d;
    logic       ack;
    logic [6:0] w;
  } iwp_row_t;
  iwp_row_t rows [5] = '{'{2'h0, 2'h0, 8'h00, 1'b1, 7'h00},
                         '{2'h0, 2'h0, 8'h7f, 1'b1, 7'h7f},
                         '{2'h3, 2'h3, 8'hd5, 1'b1, 7'h55},
                         '{2'h2, 2'h1, 8'h11, 1'b0, 7'h55},
                         '{2'h1, 2'h1, 8'h2a, 1'b1, 7'h2a}};
  logic                 clock;
  logic                 rstn;
  logic                 sel_hi;
  logic                 sel_lo;
  logic                 a0;
  logic                 a1;
  logic                 a2;
  logic [7:0]           q;
  wire                  scl;
  wire                  m_low;
  wire                  s_oe;
  wire                  s_out;
  wire                  sda;
  wire  [6:0]           wiper;
  wire  [TAP_COUNT-1:0] taps;
  int                   n_errors;
  int                   comparisons;

  // pull-up wins unless someone pulls low
  assign sda = !(m_low || (s_oe && !s_out));

  iwp_master iwp_master_inst (.scl(scl), .pull_low(m_low), .sda(sda));
  iwp_slave #(.DEVICE_CODE(CODE)) iwp_slave_inst (
    .clock(clock), .rstn(rstn), .link_clock(scl), .sda_in(sda),
    .sda_out(s_out), .sda_oe(s_oe), .bus_address_select_high(sel_hi),
    .bus_address_select_low(sel_lo), .wiper_position(wiper),
    .tap_enable(taps));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task chk1(input logic g, input logic e, input string m);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task chk7(input logic [6:0] g, input logic [6:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task do_reset();
    @(negedge clock) rstn = 1'b0;
    fork
      repeat (10) @(negedge clock);
      iwp_master_inst.pulses();
    join
    rstn = 1'b1;
    // link reset only lets go after further clock edges
    iwp_master_inst.pulses();
  endtask
  task write(input logic [4:0] c, input logic [1:0] s, input logic [7:0] d);
    iwp_master_inst.start_c();
    iwp_master_inst.put({c, s, 1'b0}, a0);
    iwp_master_inst.put(WIPER_POSITION_OFFSET, a1);
    iwp_master_inst.put(d, a2);
    iwp_master_inst.stop_c();
  endtask
  task read(input logic [1:0] s);
    iwp_master_inst.start_c();
    iwp_master_inst.put({CODE, s, 1'b1}, a0);
    iwp_master_inst.get(q);
    iwp_master_inst.stop_c();
  endtask
  task settle(input logic [6:0] w);
    repeat (20) @(negedge clock);
    chk7(wiper, w, "wiper");
    chk1(taps === (128'h1 << w), 1'b1, "tap");
  endtask

  initial begin
    rstn = 1'b0;
    {sel_hi, sel_lo} = 2'h0;
    n_errors = 0;
    comparisons = 0;
    do_reset();
    settle(WIPER_RESET);
    $display("test reset done");
    foreach (rows[i]) begin
      @(negedge clock) {sel_hi, sel_lo} = rows[i].pins;
      repeat (5) @(negedge clock);
      write(CODE, rows[i].sel, rows[i].d);
      chk1(a0, !rows[i].ack, "id ack");
      chk1(a1, !rows[i].ack, "addr ack");
      chk1(a2, !rows[i].ack, "data ack");
      settle(rows[i].w);
      read(rows[i].pins);
      chk1(a0, 1'b0, "read ack");
      chk7(q[6:0], rows[i].w, "read data");
      chk1(q[7], 1'b0, "read msb");
      $display("test row %0d done", i);
    end
    write(CODE ^ 5'h01, 2'h1, 8'h7f);
    chk1(a0, 1'b1, "bad code ack");
    settle(7'h2a);
    $display("test bad code done");
    do_reset();
    settle(WIPER_RESET);
    read(2'h1);
    chk1(a0, 1'b0, "read ack after reset");
    chk7(q[6:0], WIPER_RESET, "read after reset");
    $display("test second reset done");
    complete_run();
  end

  initial begin
    #400000;
    n_errors++;
    $display("CHECK FAILED %0t watchdog", $time);
    complete_run();
  end
endmodule

bind iwp_slave iwp_slave_monitor #(.TAPS(TAPS)) iwp_slave_monitor_inst (
  .clock(clock), .rstn(rstn), .link_clock(link_clock), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe),
  .bus_address_select_high(bus_address_select_high),
  .bus_address_select_low(bus_address_select_low),
  .wiper_position(wiper_position), .tap_enable(tap_enable));
